// ==== hdl/srt_rw_test.v ====
// Memory self-test engine: writes a pattern over the whole memory, reads it back
// and compares. Drives a memory-mapped host port with wait-request back-pressure.
// Assumes the controller makes its own memory clock and shares i_clk on this side.
//
// Functional notes
// - Write every memory location before any read-back begins.
// - Regenerate the write pattern during read-back and compare each returned word.
// - Address range and counter cover the full 64MB memory.
// - Controller takes 40MHz reference and makes its own 100MHz memory clock.
// - Trigger key press produces the controls that start a test run.
// - While the key is held all three green LEDs are lit.
// - On key release the heartbeat LED starts blinking, and the pass LED too when i_ctrl_ready is high.
// - After a clean run the pass LED stays steadily lit.
// - Any mismatch keeps the pass LED from going steady, showing failure.
// - Heartbeat LED blinks from the system clock whenever the key is released.
// - A new key press restarts a full test from the beginning.
`timescale 1ns/100ps
`default_nettype none
`include "srt_consts.vh"

module srt_rw_test #(
  parameter integer DATA_W   = `SRT_DATA_W,
  parameter integer ADDR_W   = `SRT_ADDR_W,
  parameter integer HALF_CYC = `SRT_BLINK_CYC
) (
  // Clock and reset
  input  wire              i_clk,
  input  wire              i_nrst,
  // Push-button, active low, asynchronous to i_clk
  input  wire              i_test_trigger_key_n,
  // Controller status
  input  wire              i_ctrl_ready,
  // Memory-mapped host port
  output reg  [ADDR_W-1:0] o_mem_address,
  output reg               o_mem_write,
  output reg  [DATA_W-1:0] o_mem_writedata,
  output reg               o_mem_read,
  input  wire [DATA_W-1:0] i_mem_readdata,
  input  wire              i_mem_readdatavalid,
  input  wire              i_mem_waitrequest,
  // Green LED bank
  output reg               o_reset_led,
  output reg               o_pass_led_green,
  output reg               o_heartbeat_led_green,
  // Status
  output reg               o_done,
  output reg               o_fail
);

  // ************************************************************
  // States
  // ************************************************************
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_WSEED = 3'h1;
  localparam [2:0] ST_WRITE = 3'h2;
  localparam [2:0] ST_RSEED = 3'h3;
  localparam [2:0] ST_READ  = 3'h4;
  localparam [2:0] ST_DRAIN = 3'h5;
  localparam [2:0] ST_DONE  = 3'h6;

  localparam [ADDR_W-1:0] ADDR_LAST = {ADDR_W{1'b1}};

  // ************************************************************
  // Key synchroniser
  // ************************************************************
  reg       key_s1_ff;
  reg       key_s2_ff;
  // The edge detector resets to the released level, so reset alone never starts a run.
  reg       key_prev_ff;
  wire      key_held = ~key_s2_ff;
  wire      key_rel  = key_prev_ff & ~key_s2_ff ? 1'b0 : (~key_prev_ff & key_s2_ff);

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      key_s1_ff   <= 1'b1;
      key_s2_ff   <= 1'b1;
      key_prev_ff <= 1'b1;
    end else begin
      key_s1_ff   <= i_test_trigger_key_n;
      key_s2_ff   <= key_s1_ff;
      key_prev_ff <= key_s2_ff;
    end
  end

  // ************************************************************
  // Blink source and pattern generator
  // ************************************************************
  wire        blink;
  wire [31:0] pat_word;
  reg         pat_seed;
  reg         pat_step;
  reg         cmp_step;
  wire [31:0] cmp_word;

  srt_blink #(
    .HALF_CYC (HALF_CYC)
  ) u_blink (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .o_blink (blink)
  );

  // Write-side generator feeds the write data; the compare side keeps its own copy.
  srt_lfsr u_wgen (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_seed (pat_seed),
    .i_step (pat_step),
    .o_word (pat_word)
  );

  srt_lfsr u_cgen (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_seed (pat_seed),
    .i_step (cmp_step),
    .o_word (cmp_word)
  );

  // ************************************************************
  // Sequencer
  // ************************************************************
  reg [2:0]        state_ff;
  reg [2:0]        nxt_state;
  reg [ADDR_W-1:0] addr_ff;
  reg [ADDR_W-1:0] nxt_addr;
  reg [ADDR_W:0]   pend_ff;
  reg              fail_ff;
  reg              issue_last;

  wire accepted = (o_mem_write | o_mem_read) & ~i_mem_waitrequest;
  wire rd_acc   = o_mem_read & ~i_mem_waitrequest;

  always @* begin
    nxt_state  = state_ff;
    nxt_addr   = addr_ff;
    pat_seed   = 1'b0;
    pat_step   = 1'b0;
    issue_last = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (key_rel && i_ctrl_ready) begin
          nxt_state = ST_WSEED;
        end
      end
      ST_WSEED: begin
        pat_seed  = 1'b1;
        nxt_addr  = {ADDR_W{1'b0}};
        nxt_state = ST_WRITE;
      end
      ST_WRITE: begin
        if (accepted) begin
          pat_step = 1'b1;
          nxt_addr = addr_ff + 1'b1;
          if (addr_ff == ADDR_LAST) begin
            nxt_state = ST_RSEED;
          end
        end
      end
      ST_RSEED: begin
        pat_seed  = 1'b1;
        nxt_addr  = {ADDR_W{1'b0}};
        nxt_state = ST_READ;
      end
      ST_READ: begin
        if (accepted) begin
          nxt_addr = addr_ff + 1'b1;
          if (addr_ff == ADDR_LAST) begin
            issue_last = 1'b1;
            nxt_state  = ST_DRAIN;
          end
        end
      end
      ST_DRAIN: begin
        // A controller that never returns data leaves the engine here until a key press.
        if (pend_ff == {(ADDR_W+1){1'b0}}) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_state = ST_DONE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (key_held) begin
      nxt_state = ST_IDLE;
    end
  end

  // Outstanding read count; reads whose data is still in flight.
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pend_ff <= {(ADDR_W+1){1'b0}};
    end else if (key_held) begin
      pend_ff <= {(ADDR_W+1){1'b0}};
    end else if (rd_acc && !i_mem_readdatavalid) begin
      pend_ff <= pend_ff + 1'b1;
    end else if (!rd_acc && i_mem_readdatavalid && pend_ff != {(ADDR_W+1){1'b0}}) begin
      pend_ff <= pend_ff - 1'b1;
    end
  end

  // Words that land while the key is held belong to an aborted run and are not compared.
  always @* begin
    cmp_step = i_mem_readdatavalid && !key_held &&
               (state_ff == ST_READ || state_ff == ST_DRAIN);
  end

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= ST_IDLE;
      addr_ff  <= {ADDR_W{1'b0}};
      fail_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      addr_ff  <= nxt_addr;
      // A mismatch wins over the clear; cmp_step is already low while the key is held.
      if (cmp_step && i_mem_readdata != cmp_word[DATA_W-1:0]) begin
        fail_ff <= 1'b1;
      end else if (key_held) begin
        fail_ff <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Host port drive
  // ************************************************************
  // Only the low half of the seed reaches the bus as the first word.
  localparam [31:0]       SEED_FULL = `SRT_SEED;
  localparam [DATA_W-1:0] SEED_LOW  = SEED_FULL[DATA_W-1:0];

  // Next pattern word, matching the generator's own step.
  function [DATA_W-1:0] lfsr_peek;
    input [31:0] s;
    reg   [31:0] n;
    begin
      n = s[0] ? ((s >> 1) ^ `SRT_POLY) : (s >> 1);
      lfsr_peek = n[DATA_W-1:0];
    end
  endfunction

  // Commands hold steady while wait-request is high, as the port demands.
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mem_address   <= {ADDR_W{1'b0}};
      o_mem_write     <= 1'b0;
      o_mem_writedata <= {DATA_W{1'b0}};
      o_mem_read      <= 1'b0;
    end else begin
      o_mem_address   <= nxt_addr;
      o_mem_write     <= (nxt_state == ST_WRITE);
      o_mem_read      <= (nxt_state == ST_READ) && !issue_last;
      if (state_ff == ST_WSEED) begin
        o_mem_writedata <= SEED_LOW;
      end else if (state_ff == ST_WRITE && accepted) begin
        o_mem_writedata <= lfsr_peek(pat_word);
      end
    end
  end

  // ************************************************************
  // LEDs and status
  // ************************************************************
  // The pass LED blinks while a run is busy and goes steady only on a clean finish.
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reset_led           <= 1'b0;
      o_pass_led_green      <= 1'b0;
      o_heartbeat_led_green <= 1'b0;
      o_done                <= 1'b0;
      o_fail                <= 1'b0;
    end else begin
      o_done <= (state_ff == ST_DONE);
      o_fail <= fail_ff;
      if (key_held) begin
        o_reset_led           <= 1'b1;
        o_pass_led_green      <= 1'b1;
        o_heartbeat_led_green <= 1'b1;
      end else begin
        o_reset_led           <= 1'b0;
        o_heartbeat_led_green <= blink;
        if (state_ff == ST_DONE && !fail_ff) begin
          o_pass_led_green <= 1'b1;
        end else if (state_ff == ST_IDLE) begin
          o_pass_led_green <= 1'b0;
        end else begin
          o_pass_led_green <= blink;
        end
      end
    end
  end

  // The memory clock is generated inside the controller from its reference.
  // This engine only needs i_ctrl_ready before it issues any command, since
  // commands sent during the controller's start-up would be lost.

endmodule
`default_nettype wire

// ==== hdl/srt_consts.vh ====
// Constants for the memory read/write self-test engine.
// Assumes inclusion by bare name from the design files under hdl/.
`ifndef SRT_CONSTS_VH
`define SRT_CONSTS_VH

// ************************************************************
// Memory geometry
// ************************************************************
`define SRT_MEM_BYTES      67108864
`define SRT_DATA_W         16
`define SRT_ADDR_W         25

// ************************************************************
// Timing
// ************************************************************
`define SRT_CLK_HZ         40000000
`define SRT_BLINK_HZ       2
`define SRT_BLINK_CYC      ((`SRT_CLK_HZ) / (2 * `SRT_BLINK_HZ))
`define SRT_KEY_SYNC_W     2

// ************************************************************
// Pattern generator
// ************************************************************
`define SRT_SEED           32'hace1ace1
`define SRT_POLY           32'h80200003

`endif

// ==== hdl/srt_blink.v ====
// Free-running blink divider: toggles its output at a visible rate.
// Assumes a single system clock and an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
`include "srt_consts.vh"

module srt_blink #(
  parameter integer HALF_CYC = `SRT_BLINK_CYC
) (
  // Clock and reset
  input  wire i_clk,
  input  wire i_nrst,
  // Blink output
  output reg  o_blink
);

  reg [31:0] cnt_ff;

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_ff  <= 32'h0;
      o_blink <= 1'b0;
    end else if (cnt_ff == HALF_CYC - 1) begin
      cnt_ff  <= 32'h0;
      o_blink <= ~o_blink;
    end else begin
      cnt_ff  <= cnt_ff + 32'h1;
    end
  end

endmodule
`default_nettype wire

// ==== hdl/srt_lfsr.v ====
// Pseudo-random word generator with synchronous reseed and step enable.
// Assumes a single system clock; data is valid the cycle after reseed.
`timescale 1ns/100ps
`default_nettype none
`include "srt_consts.vh"

module srt_lfsr #(
  parameter [31:0] SEED = `SRT_SEED
) (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_nrst,
  // Control
  input  wire        i_seed,
  input  wire        i_step,
  // Current pattern word
  output reg  [31:0] o_word
);

  // Galois step; a zero state cannot be reached from a non-zero seed.
  function [31:0] lfsr_next;
    input [31:0] s;
    begin
      lfsr_next = s[0] ? ((s >> 1) ^ `SRT_POLY) : (s >> 1);
    end
  endfunction

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_word <= `SRT_SEED;
    end else if (i_seed) begin
      o_word <= SEED;
    end else if (i_step) begin
      o_word <= lfsr_next(o_word);
    end
  end

endmodule
`default_nettype wire

// ==== testbench/srt_rw_test_properties.sv ====
// Port-level checker for the memory self-test engine.
// Assumes a bind from the bench top with the engine's parameter values.
`timescale 1ns/100ps
`default_nettype none
module srt_rw_test_props #(
  parameter integer DATA_W   = 16,
  parameter integer ADDR_W   = 25,
  parameter integer HALF_CYC = 4
) (
  // Clock and reset
  input wire              i_clk,
  input wire              i_nrst,
  // Key and controller
  input wire              i_test_trigger_key_n,
  input wire              i_ctrl_ready,
  // Host port
  input wire [ADDR_W-1:0] o_mem_address,
  input wire              o_mem_write,
  input wire [DATA_W-1:0] o_mem_writedata,
  input wire              o_mem_read,
  input wire [DATA_W-1:0] i_mem_readdata,
  input wire              i_mem_readdatavalid,
  input wire              i_mem_waitrequest,
  // Indicators
  input wire              o_reset_led,
  input wire              o_pass_led_green,
  input wire              o_heartbeat_led_green,
  input wire              o_done,
  input wire              o_fail
);
  // **********
  // Properties
  // **********
  // Blink bound leaves room for the key synchroniser and one full period.
  localparam int LIM = 2 * HALF_CYC + 4;
  wire wr_ok = o_mem_write && !i_mem_waitrequest;
  wire wr_end = wr_ok && (&o_mem_address);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  AST_NO_OVERLAP: assert property (!(o_mem_write && o_mem_read))
    else $error("write and read requested together");
  AST_WR_HOLD: assert property (o_mem_write && i_mem_waitrequest |=>
    o_mem_write && $stable(o_mem_address) && $stable(o_mem_writedata))
    else $error("write request dropped or changed while stalled");
  AST_WR_STEP: assert property (wr_ok && !wr_end |=>
    o_mem_write && o_mem_address == $past(o_mem_address) + 1'b1)
    else $error("write address did not advance by one");
  AST_WR_TO_RD: assert property (wr_end |=> !o_mem_write && !o_mem_read
    ##1 o_mem_read && o_mem_address == '0)
    else $error("read phase did not follow last write");
  AST_KEY_LEDS: assert property ((!i_test_trigger_key_n) [*5] |->
    o_reset_led && o_pass_led_green && o_heartbeat_led_green)
    else $error("indicators not all lit while key held");
  AST_RST_LED_OFF: assert property (i_test_trigger_key_n [*5] |-> !o_reset_led)
    else $error("reset indicator lit with key released");
  AST_PASS_STEADY: assert property ((o_done && !o_fail && i_test_trigger_key_n) [*4]
    |-> o_pass_led_green)
    else $error("pass indicator not steady after clean run");
  AST_FAIL_BLINK: assert property ($rose(o_done) && o_fail |->
    ##[1:LIM] !o_pass_led_green)
    else $error("pass indicator steady after failed run");
  AST_HEARTBEAT: assert property (i_test_trigger_key_n [*5] |->
    ##[1:LIM] $changed(o_heartbeat_led_green))
    else $error("heartbeat indicator stopped");
  cover property (o_done && !o_fail);
  cover property (o_done && o_fail);
  cover property (o_mem_read && i_mem_waitrequest);
endmodule
`default_nettype wire

// ==== testbench/srt_mem_model.sv ====
// Behavioural memory behind the host port with a fixed two-cycle read latency.
// Assumes one clock shared with the engine; stall and corruption are bench-driven.
`timescale 1ns/100ps
`default_nettype none
module srt_mem_model #(
  parameter integer DATA_W = 16,
  parameter integer ADDR_W = 4
) (
  // Clock and reset
  input  wire               i_clk,
  input  wire               i_nrst,
  // Bench controls
  input  wire               i_slow,
  input  wire               i_bad,
  // Host port
  input  wire  [ADDR_W-1:0] i_address,
  input  wire               i_write,
  input  wire  [DATA_W-1:0] i_writedata,
  input  wire               i_read,
  output logic [DATA_W-1:0] o_readdata,
  output logic              o_readdatavalid,
  output logic              o_waitrequest
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W:0]   pipe_ff;
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_waitrequest <= 1'b1;
      pipe_ff <= '0;
      o_readdatavalid <= 1'b0;
      o_readdata <= '0;
    end else begin
      o_waitrequest <= i_slow ? !o_waitrequest : 1'b0;
      if (i_write && !o_waitrequest) begin
        mem[i_address] <= i_writedata;
      end
      // Corruption flips one bit of the top word only when the bench asks.
      pipe_ff <= {i_read && !o_waitrequest,
                  mem[i_address] ^ DATA_W'(i_bad && (&i_address))};
      o_readdatavalid <= pipe_ff[DATA_W];
      // Idle data keeps changing so a stale word can never pass as valid.
      o_readdata <= pipe_ff[DATA_W] ? pipe_ff[DATA_W-1:0] : ~o_readdata;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the memory self-test engine with a shrunk memory.
// Assumes the memory model and checker files are compiled before this one.
`timescale 1ns/100ps
`default_nettype none
`include "srt_consts.vh"
module tb;
  localparam integer AW = 4;
  localparam integer HC = 4;
  logic          i_clk = 1'b0;
  logic          i_nrst = 1'b0;
  logic          i_test_trigger_key_n = 1'b1;
  logic          i_ctrl_ready = 1'b1;
  logic          slow = 1'b0;
  logic          bad = 1'b0;
  wire  [AW-1:0] o_mem_address;
  wire  [15:0]   o_mem_writedata;
  wire  [15:0]   i_mem_readdata;
  wire           o_mem_write, o_mem_read, i_mem_readdatavalid, i_mem_waitrequest;
  wire           o_reset_led, o_pass_led_green, o_heartbeat_led_green, o_done, o_fail;
  int            num_errors = 0;
  int            num_checks = 0;
  int            wcnt = 0;
  int            rcnt = 0;
  int            cycles = 0;
  logic [31:0]   wlf = `SRT_SEED;
  always #12.5 i_clk = ~i_clk;
  srt_rw_test #(.DATA_W(16), .ADDR_W(AW), .HALF_CYC(HC)) dut (.i_clk, .i_nrst,
    .i_test_trigger_key_n, .i_ctrl_ready, .o_mem_address, .o_mem_write, .o_mem_writedata,
    .o_mem_read, .i_mem_readdata, .i_mem_readdatavalid, .i_mem_waitrequest, .o_reset_led,
    .o_pass_led_green, .o_heartbeat_led_green, .o_done, .o_fail);
  srt_mem_model #(.DATA_W(16), .ADDR_W(AW)) u_mem (.i_clk, .i_nrst, .i_slow(slow),
    .i_bad(bad), .i_address(o_mem_address), .i_write(o_mem_write),
    .i_writedata(o_mem_writedata), .i_read(o_mem_read), .o_readdata(i_mem_readdata),
    .o_readdatavalid(i_mem_readdatavalid), .o_waitrequest(i_mem_waitrequest));
  // **********
  // Checking
  // **********
  task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_bit(input string n, input logic e, input logic g);
    check_word(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ `SRT_POLY) : (s >> 1);
  endfunction
  // Every accepted command is compared with the sequence worked out here.
  always @(posedge i_clk) begin
    cycles++;
    if (o_mem_write && !i_mem_waitrequest) begin
      check_word("wr_addr", wcnt, o_mem_address);
      check_word("wr_data", wlf[15:0], o_mem_writedata);
      wcnt++;
      wlf = lfsr_next(wlf);
    end
    if (o_mem_read && !i_mem_waitrequest) begin
      check_word("wr_before_rd", 1 << AW, wcnt);
      check_word("rd_addr", rcnt, o_mem_address);
      rcnt++;
    end
    if (cycles > 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  // **********
  // Scenarios
  // **********
  task automatic press();
    @(posedge i_clk) i_test_trigger_key_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    #1;
    check_bit("reset_led", 1'b1, o_reset_led);
    check_bit("pass_led", 1'b1, o_pass_led_green);
    check_bit("hb_led", 1'b1, o_heartbeat_led_green);
    wcnt = 0;
    rcnt = 0;
    wlf = `SRT_SEED;
    @(posedge i_clk) i_test_trigger_key_n <= 1'b1;
  endtask
  task automatic run_test(input logic s, input logic b, input logic f);
    int n;
    int lows;
    int tog;
    logic prev;
    int ptog;
    logic pprev;
    @(posedge i_clk) slow <= s;
    bad <= b;
    press();
    n = 0;
    ptog = 0;
    pprev = o_pass_led_green;
    while (o_done !== 1'b1 && n < 1000) begin
      @(posedge i_clk);
      #1;
      n++;
      ptog += (o_pass_led_green !== pprev);
      pprev = o_pass_led_green;
    end
    check_bit("pass_blink", 1'b1, ptog > 2);
    check_bit("done", 1'b1, o_done);
    check_word("writes", 1 << AW, wcnt);
    check_word("reads", 1 << AW, rcnt);
    check_bit("fail", f, o_fail);
    lows = 0;
    tog = 0;
    prev = o_heartbeat_led_green;
    repeat (4 * HC) begin
      @(posedge i_clk);
      #1;
      lows += !o_pass_led_green;
      tog += (o_heartbeat_led_green !== prev);
      prev = o_heartbeat_led_green;
    end
    check_bit("pass_steady", !f, lows == 0);
    check_bit("hb_blink", 1'b1, tog > 1);
  endtask
  task automatic abort_test();
    int n;
    press();
    n = 0;
    while (rcnt < 3 && n < 500) begin
      @(posedge i_clk);
      n++;
    end
    check_bit("in_read", 1'b1, rcnt >= 3);
    run_test(1'b0, 1'b0, 1'b0);
  endtask
  task automatic not_ready_test();
    @(posedge i_clk) i_ctrl_ready <= 1'b0;
    press();
    repeat (40) @(posedge i_clk);
    #1;
    check_word("writes", 0, wcnt);
    check_bit("done", 1'b0, o_done);
    check_bit("pass_idle", 1'b0, o_pass_led_green);
    @(posedge i_clk) i_ctrl_ready <= 1'b1;
  endtask
  initial begin
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk);
    run_test(1'b0, 1'b0, 1'b0);
    run_test(1'b1, 1'b0, 1'b0);
    run_test(1'b0, 1'b1, 1'b1);
    abort_test();
    not_ready_test();
    give_verdict();
  end
endmodule
bind srt_rw_test srt_rw_test_props #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .HALF_CYC(HALF_CYC))
  u_props (.i_clk, .i_nrst, .i_test_trigger_key_n, .i_ctrl_ready, .o_mem_address,
  .o_mem_write, .o_mem_writedata, .o_mem_read, .i_mem_readdata, .i_mem_readdatavalid,
  .i_mem_waitrequest, .o_reset_led, .o_pass_led_green, .o_heartbeat_led_green, .o_done,
  .o_fail);
`default_nettype wire
